//--- src/det_pkg.sv
package det_pkg;
    // Clock and channel timing
    localparam int unsigned CLK_MHZ      = 100;
    localparam int unsigned LATE_US      = 128;
    localparam int unsigned LATE_CYC     = LATE_US * CLK_MHZ;
    // Drives and command fields
    localparam int unsigned NUNITS       = 4;
    localparam int unsigned UNIT_W       = 2;
    localparam int unsigned TRACK_W      = 7;
    localparam logic [6:0]  TRACK_ZERO   = 7'h00;
    // Disc address register layout
    localparam int unsigned DA_SEC_LSB   = 0;
    localparam int unsigned DA_HEAD_LSB  = 3;
    localparam int unsigned DA_SPARE_LSB = 6;
    localparam int unsigned DA_EOT_BIT   = 7;
    localparam logic [2:0]  LAST_SECTOR  = 3'h7;
    localparam logic [7:0]  DA_RESET     = 8'h00;
    localparam logic [3:0]  CNT_RESET    = 4'h0;
    // Sector format
    localparam logic [7:0]  LAST_WORD    = 8'hff;
    localparam logic [3:0]  LAST_BIT     = 4'hf;
    localparam logic [15:0] CKW_POLY     = 16'h8005;
    localparam logic [15:0] CKW_INIT     = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_DATA = 3'h2,
        ST_CKW  = 3'h3,
        ST_END  = 3'h4
    } det_state_t;
endpackage

//--- src/det_mem.sv
`timescale 1ns/1ps
module det_mem #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 2,
    parameter int unsigned AW    = 1
) (
    input  wire logic             i_clk,
    input  wire logic             i_we,
    input  wire logic [AW-1:0]    i_waddr,
    input  wire logic [WIDTH-1:0] i_wdata,
    input  wire logic [AW-1:0]    i_raddr,
    output logic      [WIDTH-1:0] o_rdata
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem_q[i_waddr] <= i_wdata;
        end
        o_rdata <= mem_q[i_raddr];
    end
endmodule

//--- src/det_ctrl.sv
`timescale 1ns/1ps
module det_ctrl
    import det_pkg::*;
#(
    parameter int unsigned LATE_CYCLES = LATE_CYC,
    parameter int unsigned BUF_DEPTH   = 2
) (
    input  wire logic                I_CLK,
    input  wire logic                I_NRST,
    input  wire logic                I_POS_PULSE,
    input  wire logic                I_POS_RECAL,
    input  wire logic [TRACK_W-1:0]  I_POS_TRACK,
    input  wire logic [NUNITS-1:0]   I_CLR_SEEK_DONE,
    input  wire logic                I_CLR_RW_DONE,
    input  wire logic                I_LOC_PULSE,
    input  wire logic                I_LOC_UNIT_ONLY,
    input  wire logic [UNIT_W-1:0]   I_LOC_UNIT,
    input  wire logic [3:0]          I_LOC_SECTOR,
    input  wire logic [2:0]          I_LOC_HEAD,
    input  wire logic [3:0]          I_LOC_COUNT,
    input  wire logic                I_START,
    input  wire logic                I_START_WRITE,
    input  wire logic [NUNITS-1:0]   I_DRV_READY,
    input  wire logic [NUNITS-1:0]   I_DRV_POS_DONE,
    input  wire logic                I_ADDR_VLD,
    input  wire logic [TRACK_W-1:0]  I_ADDR_TRACK,
    input  wire logic [2:0]          I_ADDR_SECTOR,
    input  wire logic                I_RD_VLD,
    input  wire logic                I_RD_BIT,
    input  wire logic                I_WR_TAKE,
    input  wire logic                I_DCH_ACK,
    input  wire logic [15:0]         I_DCH_WDATA,
    output logic      [NUNITS-1:0]   O_DRV_GO,
    output logic                     O_DRV_RECAL,
    output logic      [TRACK_W-1:0]  O_DRV_TRACK,
    output logic                     O_WR_BIT,
    output logic                     O_WR_GATE,
    output logic                     O_DCH_REQ,
    output logic      [15:0]         O_DCH_RDATA,
    output logic                     O_BUSY,
    output logic                     O_DONE,
    output logic                     O_RW_DONE,
    output logic      [NUNITS-1:0]   O_SEEK_DONE,
    output logic      [NUNITS-1:0]   O_UNIT_READY,
    output logic                     O_ERROR,
    output logic                     O_EOT_ERR,
    output logic                     O_ADDR_ERR,
    output logic                     O_CKW_ERR,
    output logic                     O_LATE_ERR,
    output logic                     O_IRQ,
    output logic      [UNIT_W-1:0]   O_UNIT,
    output logic      [7:0]          O_DISC_ADDR,
    output logic      [3:0]          O_SECT_CNT
);
    localparam int unsigned AW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
    localparam int unsigned TW = $clog2(LATE_CYCLES + 1);
    localparam logic [AW:0] BUF_FULL = (AW+1)'(BUF_DEPTH);
    localparam logic [TW-1:0] LATE_LIM = TW'(LATE_CYCLES);

    function automatic logic [15:0] ckw_step(input logic [15:0] c, input logic b);
        logic fb;
        fb = c[15] ^ b;
        return {c[14:0], 1'b0} ^ (fb ? CKW_POLY : 16'h0000);
    endfunction

    det_state_t          st_q, st_d;
    logic                busy_q, done_q, rw_done_q, irq_q, wr_q;
    logic                err_q, eot_q, adr_q, ckw_q, late_q;
    logic [UNIT_W-1:0]   unit_q;
    logic [7:0]          da_q;
    logic [3:0]          cnt_q;
    logic                oor_q;
    logic [TRACK_W-1:0]  trk_q;
    logic [15:0]         sh_q, crc_q;
    logic [3:0]          bit_q;
    logic [7:0]          word_q;
    logic [AW-1:0]       wp_q, rp_q;
    logic [AW:0]         fill_q;
    logic                pop_q;
    logic [TW-1:0]       wait_q;
    logic [NUNITS-1:0]   pos_busy_q, seek_done_q, ready_q, go_q;
    logic [15:0]         mem_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Decoding
    wire       xfer      = (st_q != ST_IDLE);
    wire       start_go  = I_START & ~xfer;
    wire       sel_away  = I_LOC_PULSE & xfer & (I_LOC_UNIT != unit_q);
    wire       loc_take  = I_LOC_PULSE & ~xfer;
    wire       bit_ev    = wr_q ? I_WR_TAKE : I_RD_VLD;
    wire       data_bit  = wr_q ? sh_q[15] : I_RD_BIT;
    wire       word_end  = bit_ev & (bit_q == LAST_BIT);
    wire       addr_ok   = (I_ADDR_SECTOR == da_q[DA_SEC_LSB +: 3])
                         & (I_ADDR_TRACK == trk_q);
    wire       addr_bad  = (st_q == ST_ADDR) & I_ADDR_VLD & ~addr_ok;
    wire       addr_good = (st_q == ST_ADDR) & I_ADDR_VLD & addr_ok;
    wire [15:0] crc_nx   = ckw_step(crc_q, data_bit);
    wire [15:0] rd_word  = {sh_q[14:0], I_RD_BIT};
    wire       buf_full  = (fill_q == BUF_FULL);
    wire       buf_empty = (fill_q == '0);
    wire       rd_push   = (st_q == ST_DATA) & ~wr_q & word_end & ~buf_full;
    wire       rd_over   = (st_q == ST_DATA) & ~wr_q & word_end & buf_full;
    wire       wr_push   = wr_q & busy_q & I_DCH_ACK & ~buf_full;
    wire       push      = rd_push | wr_push;
    wire       need_wd   = addr_good & wr_q
                         | (st_q == ST_DATA) & wr_q & word_end & (word_q != LAST_WORD);
    wire       wr_pop    = need_wd & ~buf_empty & ~pop_q;
    wire       wr_under  = need_wd & (buf_empty | pop_q);
    wire       rd_pop    = ~wr_q & I_DCH_ACK & O_DCH_REQ;
    wire       pop       = wr_pop | rd_pop;
    wire       req_rd    = ~wr_q & ~buf_empty & ~pop_q;
    wire       req_wr    = wr_q & busy_q & ~buf_full;
    wire       timed_out = (O_DCH_REQ & ~I_DCH_ACK) & (wait_q == LATE_LIM);
    wire       late_ev   = rd_over | wr_under | timed_out;
    wire       ckw_bad   = (st_q == ST_CKW) & ~wr_q & word_end & (rd_word != crc_q);
    wire [3:0] cnt_inc   = cnt_q + 4'h1;
    wire       last_sec  = (da_q[DA_SEC_LSB +: 3] == LAST_SECTOR);
    wire       at_end    = (st_q == ST_END);
    wire       eot_hit   = at_end & last_sec & (cnt_inc != 4'h0);
    wire       stop_end  = at_end & ((cnt_inc == 4'h0) | eot_hit | ckw_q | late_q);
    wire       oor_stop  = start_go & oor_q;
    wire       finish    = addr_bad | stop_end | sel_away | oor_stop;
    wire       pos_go    = I_POS_PULSE;
    wire [2:0] head_inc  = da_q[DA_HEAD_LSB +: 3] + 3'h1;
    wire [1:0] spare_inc = da_q[DA_SPARE_LSB +: 2] + 2'h1;

    assign O_DCH_REQ = req_rd | req_wr;
    assign O_WR_BIT  = sh_q[15];

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE: begin
                if (start_go & ~oor_q) begin
                    st_d = ST_ADDR;
                end
            end
            ST_ADDR: begin
                if (addr_good) begin
                    st_d = ST_DATA;
                end
            end
            ST_DATA: begin
                if (word_end & (word_q == LAST_WORD)) begin
                    st_d = ST_CKW;
                end
            end
            ST_CKW: begin
                if (word_end) begin
                    st_d = ST_END;
                end
            end
            ST_END: begin
                st_d = ST_ADDR;
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
        if (finish) begin
            st_d = ST_IDLE;
        end
    end

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            st_q <= ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Controller flags
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            busy_q    <= 1'b0;
            done_q    <= 1'b0;
            rw_done_q <= 1'b0;
            irq_q     <= 1'b0;
            wr_q      <= 1'b0;
        end else begin
            irq_q <= finish | (|I_DRV_POS_DONE);
            if (start_go) begin
                busy_q <= ~oor_q;
                wr_q   <= I_START_WRITE;
            end
            if (finish) begin
                busy_q <= 1'b0;
            end
            if (finish) begin
                done_q <= 1'b1;
            end else if (pos_go | start_go) begin
                done_q <= 1'b0;
            end
            if (finish) begin
                rw_done_q <= 1'b1;
            end else if ((pos_go & I_CLR_RW_DONE) | start_go) begin
                rw_done_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            err_q  <= 1'b0;
            eot_q  <= 1'b0;
            adr_q  <= 1'b0;
            ckw_q  <= 1'b0;
            late_q <= 1'b0;
        end else begin
            if (start_go) begin
                eot_q  <= oor_q;
                err_q  <= oor_q;
                adr_q  <= 1'b0;
                ckw_q  <= 1'b0;
                late_q <= 1'b0;
            end else begin
                err_q  <= err_q | eot_hit | addr_bad | ckw_bad | late_ev;
                eot_q  <= eot_q | eot_hit;
                adr_q  <= adr_q | addr_bad;
                ckw_q  <= ckw_q | ckw_bad;
                late_q <= late_q | late_ev;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Selection, disc address and sector counter
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            unit_q <= '0;
            da_q   <= DA_RESET;
            cnt_q  <= CNT_RESET;
            oor_q  <= 1'b0;
        end else if (loc_take) begin
            unit_q <= I_LOC_UNIT;
            if (!I_LOC_UNIT_ONLY) begin
                da_q  <= {2'h0, I_LOC_HEAD, I_LOC_SECTOR[2:0]};
                cnt_q <= I_LOC_COUNT;
                oor_q <= I_LOC_SECTOR[3];
            end
        end else if (oor_stop) begin
            da_q[DA_SEC_LSB +: 3] <= 3'h0;
            oor_q                 <= 1'b0;
            if (I_START_WRITE) begin
                da_q[DA_SPARE_LSB +: 2] <= spare_inc;
            end else begin
                da_q[DA_EOT_BIT] <= 1'b1;
            end
        end else if (at_end) begin
            cnt_q                 <= cnt_inc;
            da_q[DA_SEC_LSB +: 3] <= da_q[DA_SEC_LSB +: 3] + 3'h1;
            if (eot_hit && !wr_q) begin
                da_q[DA_HEAD_LSB +: 3] <= head_inc;
            end
            if (eot_hit && wr_q) begin
                da_q[DA_SPARE_LSB +: 2] <= spare_inc;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Head positioning: one shared track register, recalibrate and track outputs; go strobe and flags per drive
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            trk_q       <= TRACK_ZERO;
            O_DRV_RECAL <= 1'b0;
            O_DRV_TRACK <= TRACK_ZERO;
        end else if (pos_go) begin
            O_DRV_RECAL <= I_POS_RECAL;
            O_DRV_TRACK <= I_POS_RECAL ? TRACK_ZERO : I_POS_TRACK;
            trk_q       <= I_POS_RECAL ? TRACK_ZERO : I_POS_TRACK;
        end
    end

    for (genvar u = 0; u < NUNITS; u++) begin : g_unit
        wire this_go = pos_go & (unit_q == UNIT_W'(u));
        always_ff @(posedge I_CLK or negedge I_NRST) begin
            if (!I_NRST) begin
                pos_busy_q[u]  <= 1'b0;
                seek_done_q[u] <= 1'b0;
                ready_q[u]     <= 1'b0;
                go_q[u]        <= 1'b0;
            end else begin
                go_q[u] <= this_go;
                if (this_go) begin
                    pos_busy_q[u] <= 1'b1;
                end else if (I_DRV_POS_DONE[u]) begin
                    pos_busy_q[u] <= 1'b0;
                end
                if (I_DRV_POS_DONE[u]) begin
                    seek_done_q[u] <= 1'b1;
                end else if (this_go | (pos_go & I_CLR_SEEK_DONE[u])) begin
                    seek_done_q[u] <= 1'b0;
                end
                ready_q[u] <= I_DRV_READY[u] & ~pos_busy_q[u] & ~this_go;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial data path and checkword
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            sh_q   <= 16'h0000;
            crc_q  <= CKW_INIT;
            bit_q  <= 4'h0;
            word_q <= 8'h00;
        end else if (addr_good) begin
            crc_q  <= CKW_INIT;
            bit_q  <= 4'h0;
            word_q <= 8'h00;
            sh_q   <= 16'h0000;
        end else if (pop_q && wr_q) begin
            sh_q <= mem_rdata;
        end else if (bit_ev && (st_q == ST_DATA || st_q == ST_CKW)) begin
            bit_q <= bit_q + 4'h1;
            sh_q  <= wr_q ? {sh_q[14:0], 1'b0} : rd_word;
            if (st_q == ST_DATA) begin
                crc_q <= crc_nx;
            end
            if (word_end && st_q == ST_DATA) begin
                word_q <= word_q + 8'h01;
                if (wr_q && word_q == LAST_WORD) begin
                    sh_q <= crc_nx;
                end else if (wr_q) begin
                    sh_q <= 16'h0000;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two-word channel buffer and latency watch
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            wp_q   <= '0;
            rp_q   <= '0;
            fill_q <= '0;
            pop_q  <= 1'b0;
            wait_q <= '0;
        end else begin
            pop_q <= pop;
            if (start_go) begin
                wp_q   <= '0;
                rp_q   <= '0;
                fill_q <= '0;
            end else begin
                if (push) begin
                    wp_q <= (wp_q == AW'(BUF_DEPTH - 1)) ? '0 : wp_q + AW'(1);
                end
                if (pop) begin
                    rp_q <= (rp_q == AW'(BUF_DEPTH - 1)) ? '0 : rp_q + AW'(1);
                end
                fill_q <= fill_q + (AW+1)'(push) - (AW+1)'(pop);
            end
            if (!O_DCH_REQ || I_DCH_ACK || timed_out) begin
                wait_q <= '0;
            end else begin
                wait_q <= wait_q + TW'(1);
            end
        end
    end

    det_mem #(
        .WIDTH (16),
        .DEPTH (BUF_DEPTH),
        .AW    (AW)
    ) u_buf (
        .i_clk   (I_CLK),
        .i_we    (push),
        .i_waddr (wp_q),
        .i_wdata (wr_q ? I_DCH_WDATA : rd_word),
        .i_raddr (rp_q),
        .o_rdata (mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign O_DCH_RDATA  = mem_rdata;
    assign O_WR_GATE    = wr_q & ((st_q == ST_DATA) | (st_q == ST_CKW));
    assign O_BUSY       = busy_q;
    assign O_DONE       = done_q;
    assign O_RW_DONE    = rw_done_q;
    assign O_SEEK_DONE  = seek_done_q;
    assign O_UNIT_READY = ready_q;
    assign O_DRV_GO     = go_q;
    assign O_ERROR      = err_q;
    assign O_EOT_ERR    = eot_q;
    assign O_ADDR_ERR   = adr_q;
    assign O_CKW_ERR    = ckw_q;
    assign O_LATE_ERR   = late_q;
    assign O_IRQ        = irq_q;
    assign O_UNIT       = unit_q;
    assign O_DISC_ADDR  = da_q;
    assign O_SECT_CNT   = cnt_q;
endmodule

//--- verification/det_properties.sv
`timescale 1ns/1ps
module det_properties
    import det_pkg::*;
#(
    parameter int unsigned LATE_CYCLES = LATE_CYC
) (
    input wire logic              I_CLK,
    input wire logic              I_NRST,
    input wire logic              I_POS_PULSE,
    input wire logic              I_POS_RECAL,
    input wire logic              I_LOC_PULSE,
    input wire logic [UNIT_W-1:0] I_LOC_UNIT,
    input wire logic [NUNITS-1:0] I_DRV_POS_DONE,
    input wire logic              I_ADDR_VLD,
    input wire logic [2:0]        I_ADDR_SECTOR,
    input wire logic              I_DCH_ACK,
    input wire logic [NUNITS-1:0] O_DRV_GO,
    input wire logic              O_DRV_RECAL,
    input wire logic              O_DCH_REQ,
    input wire logic              O_BUSY,
    input wire logic              O_DONE,
    input wire logic              O_RW_DONE,
    input wire logic [NUNITS-1:0] O_SEEK_DONE,
    input wire logic [NUNITS-1:0] O_UNIT_READY,
    input wire logic              O_ERROR,
    input wire logic              O_EOT_ERR,
    input wire logic              O_ADDR_ERR,
    input wire logic              O_CKW_ERR,
    input wire logic              O_LATE_ERR,
    input wire logic              O_IRQ,
    input wire logic [UNIT_W-1:0] O_UNIT,
    input wire logic [7:0]        O_DISC_ADDR
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_NRST);
    ////////////////////////////////////////
    // Cycles of unanswered channel request
    logic [15:0] wait_q;
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            wait_q <= 16'h0000;
        end else begin
            wait_q <= (O_DCH_REQ && O_BUSY && !I_DCH_ACK) ? wait_q + 16'h0001 : 16'h0000;
        end
    end
    ////////////////////////////////////////
    pos_done_a: assert property (I_POS_PULSE |=> !O_DONE && O_DRV_GO != 4'h0)
        else $error("positioning pulse left done set");
    recal_go_a: assert property (I_POS_PULSE && I_POS_RECAL |=> O_DRV_RECAL)
        else $error("recalibrate not passed to drive");
    pos_flags_a: assert property (I_POS_PULSE && I_DRV_POS_DONE == 4'h0 |=>
        !O_SEEK_DONE[$past(O_UNIT)] && !O_UNIT_READY[$past(O_UNIT)])
        else $error("positioning drive still ready");
    seek_irq_a: assert property (|I_DRV_POS_DONE |=> O_IRQ &&
        (O_SEEK_DONE & $past(I_DRV_POS_DONE)) == $past(I_DRV_POS_DONE))
        else $error("positioning completion lost");
    end_flags_a: assert property ($fell(O_BUSY) |-> O_DONE && O_RW_DONE && O_IRQ)
        else $error("transfer end flags wrong");
    addr_err_a: assert property (O_BUSY && I_ADDR_VLD &&
        I_ADDR_SECTOR != O_DISC_ADDR[2:0] |=> ##[0:1] (!O_BUSY && O_ADDR_ERR && O_ERROR))
        else $error("address mismatch not stopped");
    eot_zero_a: assert property ($rose(O_EOT_ERR) |->
        O_ERROR && O_DISC_ADDR[2:0] == 3'h0)
        else $error("end of track sector not zero");
    ckw_stop_a: assert property ($rose(O_CKW_ERR) |-> O_ERROR ##[0:3] !O_BUSY)
        else $error("checkword error did not stop");
    late_flag_a: assert property (wait_q == LATE_CYCLES + 3 |-> O_LATE_ERR && O_ERROR)
        else $error("slow channel not flagged late");
    deselect_a: assert property (I_LOC_PULSE && O_BUSY && I_LOC_UNIT != O_UNIT
        |=> !O_BUSY && O_DONE)
        else $error("deselect did not end transfer");
endmodule

bind det_ctrl det_properties #(.LATE_CYCLES(LATE_CYCLES)) det_properties_inst (.I_CLK, .I_NRST,
    .I_POS_PULSE, .I_POS_RECAL, .I_LOC_PULSE, .I_LOC_UNIT, .I_DRV_POS_DONE, .I_ADDR_VLD,
    .I_ADDR_SECTOR, .I_DCH_ACK, .O_DRV_GO, .O_DRV_RECAL, .O_DCH_REQ, .O_BUSY, .O_DONE,
    .O_RW_DONE, .O_SEEK_DONE, .O_UNIT_READY, .O_ERROR, .O_EOT_ERR, .O_ADDR_ERR, .O_CKW_ERR,
    .O_LATE_ERR, .O_IRQ, .O_UNIT, .O_DISC_ADDR);

//--- verification/det_chan.sv
`timescale 1ns/1ps
module det_chan (
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_req,
    input  wire logic [15:0] i_rdata,
    input  wire logic [7:0]  i_dly,
    output logic             o_ack,
    output logic      [15:0] o_wdata
);
    logic [15:0] rq[$];
    logic [15:0] sq[$];
    logic [7:0]  n;
    logic [15:0] seq;
    ////////////////////////////////////////
    // Answers a request after i_dly cycles
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_ack <= 1'b0;
            n <= 8'h00;
            seq <= 16'h5a3c;
            o_wdata <= 16'h0000;
        end else if (o_ack) begin
            rq.push_back(i_rdata);
            o_ack <= 1'b0;
            o_wdata <= ~o_wdata;
            n <= 8'h00;
        end else if (i_req && n >= i_dly) begin
            o_ack <= 1'b1;
            o_wdata <= seq;
            sq.push_back(seq);
            seq <= seq * 16'h0005 + 16'h3b1d;
        end else begin
            n <= i_req ? n + 8'h01 : 8'h00;
        end
    end
endmodule

//--- verification/tb.sv
`timescale 1ns/1ps
module tb;
    import det_pkg::*;
    logic       clk = 1'b0, nrst = 1'b0, pp = 1'b0, prc = 1'b0, crw = 1'b0, lp = 1'b0;
    logic       luo = 1'b0, st = 1'b0, sw = 1'b0, av = 1'b0, rv = 1'b0, rb = 1'b0, wt = 1'b0;
    logic [6:0] ptk = 7'h00, t = 7'h00;
    logic [3:0] csd = 4'h0, ls = 4'h0, lc = 4'h0, pdn = 4'h0;
    logic [1:0] lu = 2'h0, un;
    logic [2:0] lh = 3'h0, as = 3'h0;
    logic [7:0] dly = 8'h02, da;
    logic [3:0] go, sd, ur, cnt;
    logic [6:0] dtk;
    logic [15:0] rdat, wd;
    logic       drc, wb, wg, req, busy, done, rwd, err, eot, aer, cer, ler, irq, ack;
    int         miscompares = 0, tests_run = 0;
    det_ctrl #(.LATE_CYCLES(20)) det_ctrl_inst (.I_CLK(clk), .I_NRST(nrst), .I_POS_PULSE(pp),
        .I_POS_RECAL(prc), .I_POS_TRACK(ptk), .I_CLR_SEEK_DONE(csd), .I_CLR_RW_DONE(crw),
        .I_LOC_PULSE(lp), .I_LOC_UNIT_ONLY(luo), .I_LOC_UNIT(lu), .I_LOC_SECTOR(ls),
        .I_LOC_HEAD(lh), .I_LOC_COUNT(lc), .I_START(st), .I_START_WRITE(sw),
        .I_DRV_READY(4'hf), .I_DRV_POS_DONE(pdn), .I_ADDR_VLD(av), .I_ADDR_TRACK(t),
        .I_ADDR_SECTOR(as), .I_RD_VLD(rv), .I_RD_BIT(rb), .I_WR_TAKE(wt), .I_DCH_ACK(ack),
        .I_DCH_WDATA(wd), .O_DRV_GO(go), .O_DRV_RECAL(drc), .O_DRV_TRACK(dtk), .O_WR_BIT(wb),
        .O_WR_GATE(wg), .O_DCH_REQ(req), .O_DCH_RDATA(rdat), .O_BUSY(busy), .O_DONE(done),
        .O_RW_DONE(rwd), .O_SEEK_DONE(sd), .O_UNIT_READY(ur), .O_ERROR(err), .O_EOT_ERR(eot),
        .O_ADDR_ERR(aer), .O_CKW_ERR(cer), .O_LATE_ERR(ler), .O_IRQ(irq), .O_UNIT(un),
        .O_DISC_ADDR(da), .O_SECT_CNT(cnt));
    det_chan det_chan_inst (.i_clk(clk), .i_nrst(nrst), .i_req(req), .i_rdata(rdat),
        .i_dly(dly), .o_ack(ack), .o_wdata(wd));
    ////////////////////////////////////////
    initial begin
        forever #5 clk = ~clk;
    end
    function automatic logic [15:0] crc(input logic [15:0] c, input logic b);
        return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CKW_POLY : 16'h0000);
    endfunction
    task chk(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task finish_test;
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task pos(input logic r, input logic [6:0] k);
        @(posedge clk) pp <= 1'b1;
        prc <= r;
        ptk <= k;
        csd <= 4'h1;
        crw <= 1'b1;
        @(posedge clk) pp <= 1'b0;
        csd <= 4'h0;
        crw <= 1'b0;
        @(negedge clk) chk({done, go[0], drc, sd[0], ur[0]}, {2'b01, r, 2'b00});
        repeat (3) @(posedge clk);
        @(posedge clk) pdn <= 4'h1;
        @(posedge clk) pdn <= 4'h0;
        @(negedge clk) chk({sd[0], irq}, 2'b11);
    endtask
    task cmd(input logic [3:0] s, input logic [2:0] h, input logic [3:0] c, input logic w);
        repeat (20) @(posedge clk);
        det_chan_inst.rq.delete();
        det_chan_inst.sq.delete();
        @(posedge clk) lp <= 1'b1;
        ls <= s;
        lh <= h;
        lc <= c;
        @(posedge clk) lp <= 1'b0;
        st <= 1'b1;
        sw <= w;
        @(posedge clk) st <= 1'b0;
    endtask
    task wend;
        @(negedge clk);
        for (int i = 0; i < 9000 && busy !== 1'b0; i++) @(posedge clk);
        @(negedge clk);
    endtask
    task adr(input logic [2:0] s);
        @(posedge clk) av <= 1'b1;
        as <= s;
        @(posedge clk) av <= 1'b0;
        as <= ~s;
    endtask
    task rd(input logic [2:0] s, input logic [15:0] bad, input bit cmp);
        logic [15:0] w, ck;
        logic [15:0] ew[$];
        ck = CKW_INIT;
        adr(s);
        for (int k = 0; k < 257; k++) begin
            w = (k < 256) ? 16'($urandom) : ck ^ bad;
            if (k < 256) ew.push_back(w);
            for (int i = 15; i >= 0; i--) begin
                @(posedge clk) rv <= 1'b1;
                rb <= w[i];
                if (k < 256) ck = crc(ck, w[i]);
            end
        end
        @(posedge clk) rv <= 1'b0;
        rb <= ~rb;
        wend();
        if (cmp) begin
            chk(16'(det_chan_inst.rq.size()), 16'h0100);
            foreach (ew[i]) chk(det_chan_inst.rq[i], ew[i]);
        end
    endtask
    task wr(input logic [2:0] s);
        logic [15:0] g, ck;
        ck = CKW_INIT;
        repeat (10) @(posedge clk);
        adr(s);
        for (int i = 0; i < 50 && wg !== 1'b1; i++) @(posedge clk);
        for (int k = 0; k < 257; k++) begin
            for (int i = 15; i >= 0; i--) begin
                @(posedge clk) wt <= 1'b1;
                @(negedge clk) g[i] = wb;
                @(posedge clk) wt <= 1'b0;
                if (k < 256) ck = crc(ck, g[i]);
            end
            chk(g, (k < 256) ? det_chan_inst.sq[k] : ck);
        end
        wend();
    endtask
    ////////////////////////////////////////
    initial begin
        void'($urandom(50));
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        t = 7'($urandom % 77);
        pos(1'b1, 7'($urandom));
        pos(1'b0, t);
        cmd(4'h8 | 4'($urandom % 8), 3'h5, 4'hf, 1'b1);
        wend();
        chk({err, eot, done, busy, da}, {4'b1110, 2'b01, 3'h5, 3'h0});
        cmd(4'h8 | 4'($urandom % 8), 3'h5, 4'hf, 1'b0);
        wend();
        chk({err, eot, da[7], da[5:0]}, {3'b111, 3'h5, 3'h0});
        for (int w = 0; w < 2; w++) begin
            cmd(4'h3, 3'h1, 4'he, w[0]);
            adr(3'h4);
            wend();
            chk({aer, err, da[2:0], cnt}, {2'b11, 3'h3, 4'he});
        end
        cmd(4'h7, 3'h2, 4'he, 1'b0);
        rd(3'h7, 16'h0000, 1'b1);
        chk({eot, err, da[5:0], cnt}, {2'b11, 3'h3, 3'h0, 4'hf});
        cmd(4'h2, 3'h1, 4'hd, 1'b0);
        rd(3'h2, 16'h0001, 1'b0);
        chk({cer, err, busy, da[2:0], cnt}, {3'b110, 3'h3, 4'he});
        dly <= 8'h28;
        cmd(4'h4, 3'h1, 4'hf, 1'b0);
        rd(3'h4, 16'h0000, 1'b0);
        dly <= 8'h02;
        chk({ler, err, da[2:0], cnt}, {2'b11, 3'h5, 4'h0});
        cmd(4'h7, 3'h0, 4'he, 1'b1);
        wr(3'h7);
        chk({eot, err, da[2:0], cnt}, {2'b11, 3'h0, 4'hf});
        cmd(4'h0, 3'h0, 4'hf, 1'b0);
        adr(3'h0);
        repeat (20) @(posedge clk);
        @(posedge clk) lp <= 1'b1;
        luo <= 1'b1;
        lu <= 2'h1;
        @(posedge clk);
        @(posedge clk) lp <= 1'b0;
        luo <= 1'b0;
        @(negedge clk) chk({busy, done, un}, {2'b01, 2'h1});
        finish_test();
    end
    initial begin
        #600000;
        miscompares++;
        finish_test();
    end
endmodule
